/* stm_pkg.sv */
/*
 * Package for the 10-bit standard timer: register map, field positions,
 * reset values, clock-select and mode encodings.
 * Assumes an Avalon-MM slave with 32-bit words, one register per word.
 */
package stm_pkg;
    localparam int STM_CW = 10;

    // Word byte addresses
    localparam logic [4:0] STM_OFF_CTRL0 = 5'h00;
    localparam logic [4:0] STM_OFF_CTRL1 = 5'h04;
    localparam logic [4:0] STM_OFF_CNTL  = 5'h08;
    localparam logic [4:0] STM_OFF_CNTH  = 5'h0C;
    localparam logic [4:0] STM_OFF_CMPL  = 5'h10;
    localparam logic [4:0] STM_OFF_CMPH  = 5'h14;
    localparam logic [4:0] STM_OFF_FLAG  = 5'h18;

    localparam logic [7:0] STM_CTRL0_RST = 8'h00;
    localparam logic [7:0] STM_CTRL1_RST = 8'h00;
    localparam logic [9:0] STM_CMP_RST   = 10'h000;
    localparam logic [9:0] STM_CNT_MAX   = 10'h3FF;

    // Control 0 fields
    localparam int STM_B_PAUSE = 7;
    localparam int STM_B_CKHI  = 6;
    localparam int STM_B_CKLO  = 4;
    localparam int STM_B_RUN   = 3;
    localparam int STM_B_PRHI  = 2;
    // Control 1 fields
    localparam int STM_B_MDHI  = 7;
    localparam int STM_B_MDLO  = 6;
    localparam int STM_B_PFHI  = 5;
    localparam int STM_B_PFLO  = 4;
    localparam int STM_B_INIT  = 3;
    localparam int STM_B_POL   = 2;
    localparam int STM_B_DPX   = 1;
    localparam int STM_B_CCLR  = 0;

    // Clock select
    localparam logic [2:0] STM_CK_SYS4  = 3'h0;
    localparam logic [2:0] STM_CK_SYS   = 3'h1;
    localparam logic [2:0] STM_CK_H16   = 3'h2;
    localparam logic [2:0] STM_CK_H64   = 3'h3;
    localparam logic [2:0] STM_CK_SUB0  = 3'h4;
    localparam logic [2:0] STM_CK_SUB1  = 3'h5;
    localparam logic [2:0] STM_CK_EXTR  = 3'h6;
    localparam logic [2:0] STM_CK_EXTF  = 3'h7;

    // Divider counts
    localparam int STM_DIV_SYS4 = 4;
    localparam int STM_DIV_H16  = 16;
    localparam int STM_DIV_H64  = 64;

    // Operating modes
    localparam logic [1:0] STM_MD_CMP  = 2'h0;
    localparam logic [1:0] STM_MD_UND  = 2'h1;
    localparam logic [1:0] STM_MD_PWM  = 2'h2;
    localparam logic [1:0] STM_MD_TMR  = 2'h3;

    // Pin function codes
    localparam logic [1:0] STM_PF_00 = 2'h0;
    localparam logic [1:0] STM_PF_01 = 2'h1;
    localparam logic [1:0] STM_PF_10 = 2'h2;
    localparam logic [1:0] STM_PF_11 = 2'h3;
endpackage

/* stm_sync.sv */
/*
 * Two-flop synchroniser for the external clock pin, with edge outputs
 * taken from the second and third flops.
 * Assumes pin_i is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module stm_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin and edges
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    import stm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } stm_sync_st_t;

    stm_sync_st_t st;
    stm_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (rst_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // Edges seen only behind the second flop
    assign rise_o = st.s2 & ~st.s3;
    assign fall_o = ~st.s2 & st.s3;
endmodule

/* stm_tick.sv */
/*
 * Counter tick generator: dividers and clock-source selection.
 * Assumes high and sub clock rates come as one-cycle enables on clk_i.
 */
`timescale 1ns/1ps
module stm_tick (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Source enables
    input  wire logic       high_en_i,
    input  wire logic       sub_en_i,
    input  wire logic       ext_rise_i,
    input  wire logic       ext_fall_i,
    // Selection and tick
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    import stm_pkg::*;

    typedef struct packed {
        logic [1:0] d4;
        logic [5:0] dh;
    } stm_tick_st_t;

    stm_tick_st_t st;
    stm_tick_st_t next_st;
    logic         t4;
    logic         t16;
    logic         t64;

    assign t4  = (st.d4 == 2'(STM_DIV_SYS4 - 1));
    assign t16 = high_en_i & (st.dh[3:0] == 4'(STM_DIV_H16 - 1));
    assign t64 = high_en_i & (st.dh == 6'(STM_DIV_H64 - 1));

    always_comb begin
        next_st    = st;
        next_st.d4 = st.d4 + 2'h1;
        if (high_en_i) begin
            next_st.dh = st.dh + 6'h01;
        end
        if (rst_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    always_comb begin
        case (sel_i)
            STM_CK_SYS4: tick_o = t4;
            STM_CK_SYS:  tick_o = 1'b1;
            STM_CK_H16:  tick_o = t16;
            STM_CK_H64:  tick_o = t64;
            STM_CK_SUB0: tick_o = sub_en_i;
            STM_CK_SUB1: tick_o = sub_en_i;
            STM_CK_EXTR: tick_o = ext_rise_i;
            STM_CK_EXTF: tick_o = ext_fall_i;
            default:     tick_o = 1'b0;
        endcase
    end
endmodule

/* stm_top.sv */
/*
 * 10-bit standard timer: counter, period and compare-A comparators,
 * output pin logic and Avalon-MM register slave.
 * Assumes one clock, synchronous reset, high/sub clock enables on clk_i.
 */
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
// Function
// - 10-bit up-counter on selected clock
// - period vs top 3 bits; A vs all
// - no counter load; run rise clears
// - overflow or selected match clears, raises event
// - pause holds counter, resumes on release
// - clock select field picks tick source
// - run off stops, counter keeps value
// - run rise restores initial pin level
// - period 0 is 1024, else N*128
// - clear select picks A or period/overflow
// - clear select ignored in PWM modes
// - mode field selects operating mode
// - compare mode: none, low, high, toggle
// - PWM mode: inactive, active, PWM, pulse
// - no change if requested equals initial
// - initial bit sets level or active sense
// - polarity bit inverts pin, not timer mode
// - duty/period select swaps PWM roles
// - counter read-only, compare-A read/write
// - timer mode leaves pin unused
// - A-clear compare mode: no period flag
// - compare A zero: overflow, no A flag
// - duty at or above period gives 100%
// - inverse pin always mirrors output pin
`timescale 1ns/1ps
module stm_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Clock enables and pins
    input  wire logic        high_en_i,
    input  wire logic        sub_en_i,
    input  wire logic        external_clock_pin_i,
    output logic             timer_output_pin_o,
    output logic             timer_output_pin_inverse_o,
    // Match events
    output logic             compare_a_flag_o,
    output logic             period_match_flag_o
);
    import stm_pkg::*;

    typedef struct packed {
        logic [7:0]        ctrl0;
        logic [7:0]        ctrl1;
        logic [9:0]        cmp;
        logic [9:0]        cnt;
        logic              run_d;
        logic              lvl;
        logic              pulse_done;
        logic              pin;
        logic              pinb;
        logic              af;
        logic              pf;
        logic              afs;
        logic              pfs;
        logic              ack;
        logic              wreq;
        logic [31:0]       rdata;
    } stm_st_t;

    stm_st_t    st;
    stm_st_t    next_st;
    logic       ext_rise;
    logic       ext_fall;
    logic       tick;
    logic       run;
    logic       init_b;
    logic [1:0] mode;
    logic [1:0] pfn;
    logic [2:0] prd;
    logic       pwm;
    logic       ccl;
    logic       run_rise;
    logic       a_hit;
    logic       p_hit;
    logic       ovf;
    logic       clr;
    logic [9:0] nxt;
    logic [10:0] per_v;
    logic [10:0] a_ext;
    logic [10:0] period_len;
    logic [10:0] duty_len;
    logic       duty_on;
    logic       raw;
    logic       acc;
    logic [7:0] be0;

    stm_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (external_clock_pin_i),
        .rise_o (ext_rise),
        .fall_o (ext_fall)
    );

    stm_tick u_tick (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .high_en_i  (high_en_i),
        .sub_en_i   (sub_en_i),
        .ext_rise_i (ext_rise),
        .ext_fall_i (ext_fall),
        .sel_i      (st.ctrl0[STM_B_CKHI:STM_B_CKLO]),
        .tick_o     (tick)
    );

    assign run      = st.ctrl0[STM_B_RUN];
    assign prd      = st.ctrl0[STM_B_PRHI:0];
    assign mode     = st.ctrl1[STM_B_MDHI:STM_B_MDLO];
    assign pfn      = st.ctrl1[STM_B_PFHI:STM_B_PFLO];
    assign init_b   = st.ctrl1[STM_B_INIT];
    assign pwm      = (mode == STM_MD_PWM);
    assign ccl      = st.ctrl1[STM_B_CCLR] & ~pwm;
    assign run_rise = run & ~st.run_d;
    assign nxt      = st.cnt + 10'h001;

    // Comparators act on the count about to be reached
    assign p_hit = (prd != 3'h0) && (nxt[9:7] == prd)
                   && (nxt[6:0] == 7'h00);
    assign ovf   = (st.cnt == STM_CNT_MAX);
    assign a_hit = (st.cmp != 10'h000) && (nxt == st.cmp);

    // PWM period and duty lengths in counter clocks
    assign per_v = (prd == 3'h0) ? 11'h400 : {1'b0, prd, 7'h00};
    assign a_ext = {1'b0, st.cmp};
    assign period_len = st.ctrl1[STM_B_DPX] ? a_ext : per_v;
    assign duty_len   = st.ctrl1[STM_B_DPX] ? per_v : a_ext;
    // Duty not below period stays active all period
    assign duty_on = (duty_len >= period_len)
                     || ({1'b0, st.cnt} < duty_len);

    always_comb begin
        clr = 1'b0;
        if (pwm) begin
            clr = st.ctrl1[STM_B_DPX] ? a_hit : (p_hit | ovf);
        end else if (ccl) begin
            clr = a_hit | ovf;
        end else begin
            clr = p_hit | ((prd == 3'h0) & ovf);
        end
    end

    assign acc = (avs_read_i | avs_write_i) & ~st.ack;
    assign be0 = {8{avs_byteenable_i[0]}};

    always_comb begin
        next_st       = st;
        next_st.run_d = run;
        next_st.afs   = 1'b0;
        next_st.pfs   = 1'b0;
        raw           = st.lvl;

        // Counter advance, pause and clear
        if (run_rise) begin
            next_st.cnt = 10'h000;
        end else if (run && !st.ctrl0[STM_B_PAUSE] && tick) begin
            next_st.cnt = clr ? 10'h000 : nxt;
            next_st.afs = a_hit;
            next_st.pfs = (p_hit | ((prd == 3'h0) & ovf)) & ~ccl;
        end

        // Output level machine
        if (run_rise) begin
            next_st.lvl        = init_b;
            next_st.pulse_done = 1'b0;
        end else if (next_st.afs && mode == STM_MD_CMP) begin
            case (pfn)
                STM_PF_00: next_st.lvl = st.lvl;
                STM_PF_01: next_st.lvl = 1'b0;
                STM_PF_10: next_st.lvl = 1'b1;
                STM_PF_11: next_st.lvl = ~st.lvl;
                default:   next_st.lvl = st.lvl;
            endcase
        end else if (pwm && pfn == STM_PF_11 && next_st.afs) begin
            next_st.pulse_done = 1'b1;
        end

        case (mode)
            STM_MD_PWM: begin
                case (pfn)
                    STM_PF_00: raw = ~init_b;
                    STM_PF_01: raw = init_b;
                    STM_PF_10: raw = duty_on ? init_b : ~init_b;
                    STM_PF_11: raw = (run && !st.pulse_done) ? init_b : ~init_b;
                    default:   raw = ~init_b;
                endcase
            end
            STM_MD_CMP: raw = st.lvl;
            default:    raw = 1'b0;
        endcase
        next_st.pin  = (mode == STM_MD_TMR) ? 1'b0
                     : raw ^ st.ctrl1[STM_B_POL];
        next_st.pinb = ~next_st.pin;
        next_st.af   = next_st.afs;
        next_st.pf   = next_st.pfs;

        // Bus slave: one wait state per access
        next_st.ack   = acc;
        next_st.wreq  = ~acc;
        next_st.rdata = 32'h0000_0000;
        if (acc && avs_read_i) begin
            case (avs_address_i)
                STM_OFF_CTRL0: next_st.rdata = {24'h0, st.ctrl0};
                STM_OFF_CTRL1: next_st.rdata = {24'h0, st.ctrl1};
                STM_OFF_CNTL:  next_st.rdata = {24'h0, st.cnt[7:0]};
                STM_OFF_CNTH:  next_st.rdata = {30'h0, st.cnt[9:8]};
                STM_OFF_CMPL:  next_st.rdata = {24'h0, st.cmp[7:0]};
                STM_OFF_CMPH:  next_st.rdata = {30'h0, st.cmp[9:8]};
                default:       next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (acc && avs_write_i) begin
            case (avs_address_i)
                STM_OFF_CTRL0: next_st.ctrl0 = (avs_writedata_i[7:0] & be0)
                                             | (st.ctrl0 & ~be0);
                STM_OFF_CTRL1: next_st.ctrl1 = (avs_writedata_i[7:0] & be0)
                                             | (st.ctrl1 & ~be0);
                STM_OFF_CMPL: begin
                    if (avs_byteenable_i[0]) begin
                        next_st.cmp[7:0] = avs_writedata_i[7:0];
                    end
                end
                STM_OFF_CMPH: begin
                    if (avs_byteenable_i[0]) begin
                        next_st.cmp[9:8] = avs_writedata_i[1:0];
                    end
                end
                default: next_st.cmp = st.cmp;
            endcase
        end

        if (rst_i) begin
            next_st       = '0;
            next_st.ctrl0 = STM_CTRL0_RST;
            next_st.ctrl1 = STM_CTRL1_RST;
            next_st.cmp   = STM_CMP_RST;
            next_st.pinb  = 1'b1;
            next_st.wreq  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign avs_readdata_o             = st.rdata;
    // Registered; high while idle, low only in the answer cycle
    assign avs_waitrequest_o          = st.wreq;
    assign timer_output_pin_o         = st.pin;
    assign timer_output_pin_inverse_o = st.pinb;
    assign compare_a_flag_o           = st.af;
    assign period_match_flag_o        = st.pf;

    AST_RUN_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        run_rise |=> (st.cnt == 10'h000))
        else $error("counter not cleared on run rise");
    AST_PAUSE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctrl0[STM_B_PAUSE] && st.run_d && run) |=> $stable(st.cnt))
        else $error("counter moved while paused");
    AST_OFF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run && !st.run_d) |=> $stable(st.cnt))
        else $error("counter moved while off");
    AST_INV_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (timer_output_pin_inverse_o == ~timer_output_pin_o))
        else $error("inverse pin mismatch");
    AST_NO_PF: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctrl1[STM_B_CCLR] && mode == STM_MD_CMP) ##1
        (st.ctrl1[STM_B_CCLR] && mode == STM_MD_CMP) |-> !st.pf)
        else $error("period flag with A clear");
    AST_A_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.cmp == 10'h000) |=> !st.afs)
        else $error("A flag with zero compare");
    AST_INIT_LVL: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_rise && mode == STM_MD_CMP) |=> (st.lvl == $past(init_b)))
        else $error("initial level not restored");
    AST_CLR_A: assert property (@(posedge clk_i) disable iff (rst_i)
        (ccl && mode == STM_MD_CMP && run && st.run_d && tick
         && !st.ctrl0[STM_B_PAUSE] && a_hit) |=> (st.cnt == 10'h000))
        else $error("no clear on A match");
    AST_FULL_DUTY: assert property (@(posedge clk_i) disable iff (rst_i)
        (pwm && pfn == STM_PF_10 && duty_len >= period_len)
        |=> (st.pin == ($past(init_b) ^ $past(st.ctrl1[STM_B_POL]))))
        else $error("full duty not held");
endmodule

/* stm_tb.sv */
/*
 * Self-checking bench for stm_top: Avalon-MM register access, flag
 * intervals, pin levels and PWM duty counts.
 * Assumes the register map and bit positions of stm_pkg.
 */
`timescale 1ns/1ps
module tb;
    import stm_pkg::*;
    logic        clk_i, rst_i, rd_i, wr_i, wait_o, hi_en, sub_en, ext_pin;
    logic        pin_o, pinb_o, af_o, pf_o, ini, pol;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat;
    logic [31:0] exp_q[$];
    logic [9:0]  a;
    int          bad_count, n_checks, cyc, naf, npf, n, m, naf0, npf0, e;

    stm_top i_stm_top (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .avs_address_i              (adr),
        .avs_read_i                 (rd_i),
        .avs_write_i                (wr_i),
        .avs_writedata_i            (wdat),
        .avs_byteenable_i           (4'hF),
        .avs_readdata_o             (rdat),
        .avs_waitrequest_o          (wait_o),
        .high_en_i                  (hi_en),
        .sub_en_i                   (sub_en),
        .external_clock_pin_i       (ext_pin),
        .timer_output_pin_o         (pin_o),
        .timer_output_pin_inverse_o (pinb_o),
        .compare_a_flag_o           (af_o),
        .period_match_flag_o        (pf_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_v(input string w, input logic [31:0] x,
                         input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", w, x, g);
        end
    endtask

    task automatic chk_n(input string w, input int x, input int g);
        n_checks++;
        if (g != x) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", w, x, g);
        end
    endtask

    // One access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] ad,
                       input logic [7:0] d);
        adr <= ad;
        wdat <= {24'h000000, d};
        wr_i <= w;
        rd_i <= ~w;
        do @(posedge clk_i); while (wait_o !== 1'b0);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] ad, input logic [7:0] x);
        exp_q.push_back({24'h000000, x});
        bus(1'b0, ad, 8'h00);
    endtask

    task automatic cfg(input logic [7:0] c0, input logic [7:0] c1,
                       input logic [9:0] av);
        bus(1'b1, STM_OFF_CTRL0, 8'h00);
        bus(1'b1, STM_OFF_CTRL1, c1);
        bus(1'b1, STM_OFF_CMPL, av[7:0]);
        bus(1'b1, STM_OFF_CMPH, {6'h00, av[9:8]});
        bus(1'b1, STM_OFF_CTRL0, c0);
    endtask

    // Cycles up to the next pulse of the chosen flag
    task automatic wf(input logic s, output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((s ? pf_o : af_o) !== 1'b1);
    endtask

    // High cycles k over one flag-to-flag window of m cycles
    task automatic hi(input logic s, output int k, output int m);
        wf(s, m);
        k = 0;
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
            if (pin_o === 1'b1) k++;
        end while ((s ? pf_o : af_o) !== 1'b1);
    endtask

    // Read data, flag counts, inverse pin, timeout
    always @(posedge clk_i) begin
        cyc++;
        hi_en <= 1'($urandom);
        sub_en <= 1'($urandom);
        if (rd_i && wait_o === 1'b0) begin
            chk_v("readdata", exp_q.pop_front(), rdat);
        end
        if (af_o === 1'b1) naf++;
        if (pf_o === 1'b1) npf++;
        if (!rst_i) chk_v("inverse pin", {31'h0, ~pin_o}, {31'h0, pinb_o});
        if (cyc == 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'hAB5C));
        {rd_i, wr_i, hi_en, sub_en, ext_pin} = 5'h00;
        adr = 5'h00;
        wdat = 32'h0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_v("pin at reset", 32'h0, {31'h0, pin_o});
        rd(STM_OFF_CTRL0, STM_CTRL0_RST);
        rd(STM_OFF_CTRL1, STM_CTRL1_RST);
        rd(STM_OFF_CMPL, STM_CMP_RST[7:0]);
        rd(STM_OFF_FLAG, 8'h00);
        bus(1'b1, STM_OFF_CTRL1, 8'hA5);
        rd(STM_OFF_CTRL1, 8'hA5);
        // Paused from run rise: counter cleared and held
        cfg({1'b1, STM_CK_SYS, 1'b1, 3'h0}, 8'h01, 10'd20);
        repeat (40) @(posedge clk_i);
        rd(STM_OFF_CNTL, 8'h00);
        bus(1'b1, STM_OFF_CNTL, 8'h5A);
        rd(STM_OFF_CNTL, 8'h00);
        chk_n("flags while paused", 0, naf);
        bus(1'b1, STM_OFF_CTRL0, {1'b0, STM_CK_SYS, 1'b1, 3'h0});
        wf(1'b0, n);
        wf(1'b0, n);
        chk_n("A interval", 20, n);
        // Compare mode, every pin function
        for (int f = 0; f < 4; f++) begin
            a = 10'd16 + 10'($urandom % 48);
            ini = 1'($urandom);
            pol = 1'($urandom);
            cfg({1'b0, STM_CK_SYS, 1'b1, 3'h1},
                {STM_MD_CMP, 2'(f), ini, pol, 2'b01}, a);
            npf0 = npf;
            repeat (3) @(posedge clk_i);
            chk_v("initial pin", {31'h0, ini ^ pol}, {31'h0, pin_o});
            wf(1'b0, n);
            repeat (4) @(posedge clk_i);
            e = (f == 0) ? ini : (f == 1) ? 0 : (f == 2) ? 1 : !ini;
            chk_v("pin after match", {31'h0, 1'(e) ^ pol}, {31'h0, pin_o});
            wf(1'b0, n);
            wf(1'b0, n);
            chk_n("A interval", int'(a), n);
            chk_n("period flags", npf0, npf);
        end
        // Period clear at both system clock rates, then overflow
        for (int i = 0; i < 2; i++) begin
            cfg({1'b0, i ? STM_CK_SYS : STM_CK_SYS4, 1'b1, 3'h1},
                i ? 8'hC0 : 8'h00, 10'h3FF);
            wf(1'b1, n);
            wf(1'b1, n);
            if (i) chk_v("timer mode pin", 32'h0, {31'h0, pin_o});
            chk_n("period", i ? 128 : 128 * STM_DIV_SYS4, n);
        end
        cfg({1'b0, STM_CK_SYS, 1'b1, 3'h0}, 8'h00, 10'h000);
        naf0 = naf;
        wf(1'b1, n);
        wf(1'b1, n);
        chk_n("overflow period", 1024, n);
        chk_n("A flags with A zero", naf0, naf);
        // PWM pin functions and full duty
        for (int i = 0; i < 5; i++) begin
            a = (i == 4) ? 10'd128 : 10'd1 + 10'($urandom % 120);
            pol = 1'($urandom);
            cfg({1'b0, STM_CK_SYS, 1'b1, 3'h1},
                {STM_MD_PWM, (i == 4) ? STM_PF_10 : 2'(i), 1'b1, pol,
                 1'b0, 1'b1}, a);
            hi(1'b1, n, m);
            e = (i == 1 || i == 4) ? 128 : (i == 2) ? int'(a) : 0;
            chk_n("PWM high cycles", pol ? 128 - e : e, n);
        end
        cfg({1'b0, STM_CK_SYS, 1'b1, 3'h1},
            {STM_MD_PWM, STM_PF_10, 4'b1010}, 10'd300);
        hi(1'b0, n, m);
        chk_n("swapped period", 300, m);
        chk_n("swapped duty", 128, n);
        // External pin edges, synchronised
        for (int s = 0; s < 2; s++) begin
            cfg({1'b0, s ? STM_CK_EXTF : STM_CK_EXTR, 1'b1, 3'h0}, 8'h01,
                10'd3);
            naf0 = naf;
            repeat (5) begin
                repeat (6) @(posedge clk_i);
                ext_pin <= ~ext_pin;
            end
            repeat (6) @(posedge clk_i);
            chk_n("flags at third rise", s ? 0 : 1, naf - naf0);
            ext_pin <= 1'b0;
            repeat (6) @(posedge clk_i);
            chk_n("flags at third fall", 1, naf - naf0);
        end
        // Run off keeps the residual count
        cfg({1'b0, STM_CK_EXTR, 1'b1, 3'h0}, 8'h01, 10'h3FF);
        repeat (4) begin
            repeat (6) @(posedge clk_i);
            ext_pin <= ~ext_pin;
        end
        bus(1'b1, STM_OFF_CTRL0, {1'b0, STM_CK_EXTR, 1'b0, 3'h0});
        repeat (2) begin
            repeat (6) @(posedge clk_i);
            ext_pin <= ~ext_pin;
        end
        repeat (6) @(posedge clk_i);
        rd(STM_OFF_CNTL, 8'h02);
        bus(1'b1, STM_OFF_CTRL0, {1'b0, STM_CK_EXTR, 1'b1, 3'h0});
        rd(STM_OFF_CNTL, 8'h00);
        rd(STM_OFF_CNTH, 8'h00);
        wrap_up();
    end
endmodule
